//--- hdl/cmw_pkg.sv
// Package: constants and carriers of the continuous multi-turn wrap block
// Overview of operation
// RULE1: First enabled power-up raises limit mismatch error
// RULE2: Later power-ups with matching limit raise nothing
// RULE3: Offset beyond span raises parameter error six
// RULE4: Start-up writes limit into encoder side
// RULE5: Operator sets method 4, limit, re-powers
// RULE6: Host seeds command position from actual position
// RULE7: Actual position wraps at span minus one
// RULE8: Encoder keeps limit while battery stays
// RULE9: Multi-turn wraps to zero or limit
// RULE10: Method 4 ignores multi-turn overflow
// RULE11: Position is turns, single-turn, plus offset
package cmw_pkg;
  // Register byte offsets
  localparam logic [7:0] CMW_CTRL   = 8'h00;
  localparam logic [7:0] CMW_LIMIT  = 8'h04;
  localparam logic [7:0] CMW_OFFSET = 8'h08;
  localparam logic [7:0] CMW_POS    = 8'h0c;
  localparam logic [7:0] CMW_STATUS = 8'h10;
  localparam logic [7:0] CMW_CLEAR  = 8'h14;
  localparam logic [7:0] CMW_ENABLE = 8'h18;
  localparam logic [7:0] CMW_STATE  = 8'h1c;
  // Field positions and codes
  localparam int         CMW_START_BIT = 8;
  localparam logic [2:0] CMW_MODE_CONT = 3'h4;
  localparam int         CMW_SBITS     = 23;
  localparam int         CMW_MBITS     = 16;
  localparam logic [15:0] CMW_LIM_ABS  = 16'hffff;
  localparam logic [15:0] CMW_LIM_MIN  = 16'h0001;
  // Event bits
  localparam int CMW_EV_MISM = 0;
  localparam int CMW_EV_PERR = 1;
  localparam int CMW_EV_OVF  = 2;
  localparam int CMW_EV_WRAP = 3;
  localparam int CMW_NEV     = 4;

  typedef enum logic [2:0] {
    CMW_IDLE  = 3'b001,
    CMW_CHECK = 3'b010,
    CMW_RUN   = 3'b100
  } cmw_state_e;

  // Software visible settings
  typedef struct packed {
    logic [2:0]          mode;
    logic [15:0]         limit;
    logic [31:0]         offset;
    logic [CMW_NEV-1:0]  status;
    logic [CMW_NEV-1:0]  enable;
  } cmw_regs_s;

  // Whole state of the block
  typedef struct packed {
    cmw_state_e  fsm;
    cmw_regs_s   regs;
    logic [15:0] enc_limit;
    logic        enc_valid;
    logic        enc_we;
    logic [15:0] mturn;
    logic [31:0] reported_actual_position;
    logic        mism;
    logic        perr;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } cmw_state_s;
endpackage

//--- hdl/cmw_wrap.sv
// Continuous multi-turn absolute position wrap with Wishbone registers
`timescale 1ns/1ns
module cmw_wrap
  import cmw_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        power_up_i,
  input  wire logic        battery_ok_i,
  input  wire logic [22:0] enc_single_i,
  input  wire logic        enc_step_up_i,
  input  wire logic        enc_step_dn_i,
  output logic      [15:0] enc_limit_o,
  output logic             enc_limit_we_o,
  output logic      [31:0] reported_actual_position_o,
  output logic             mismatch_o,
  output logic             param_err_o,
  output logic             irq_o
);
  // Reset release through two flops
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  cmw_state_s st;
  cmw_state_s next_st;

  logic             cont;
  logic [15:0]      lim_eff;
  logic [39:0]      span;
  logic [39:0]      raw;
  logic [39:0]      pos;
  logic             bad_ofs;
  logic             wr;
  logic             rd;
  logic [31:0]      wmask;
  logic [CMW_NEV-1:0] ev;
  logic [CMW_NEV-1:0] clr;
  logic             start;

  // Span and offset range follow the live settings
  always_comb begin
    cont    = (st.regs.mode == CMW_MODE_CONT);
    // Limit zero behaves like one; other modes use the full range
    if (!cont) begin
      lim_eff = CMW_LIM_ABS;
    end else if (st.regs.limit == 16'h0000) begin
      lim_eff = CMW_LIM_MIN;
    end else begin
      lim_eff = st.regs.limit;
    end
    span    = {7'h00, {1'b0, lim_eff} + 17'h00001, 16'h0000} >> 16
              << CMW_SBITS;
    bad_ofs = cont && ({8'h00, st.regs.offset} > (span - 40'h1)); // [RULE3]
    raw     = {1'b0, st.mturn, enc_single_i};                    // [RULE11]
    pos     = raw + {8'h00, st.regs.offset};                     // [RULE11]
    if (cont && (pos >= span)) begin
      pos = pos - span;                                          // [RULE7]
    end
    wr      = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
    rd      = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    clr     = (wr && (wb_adr_i == CMW_CLEAR)) ?
              (wb_dat_i[CMW_NEV-1:0] & wmask[CMW_NEV-1:0]) : '0;
    start   = power_up_i || (wr && (wb_adr_i == CMW_CTRL) &&
              wb_sel_i[1] && wb_dat_i[CMW_START_BIT]);
  end

  // Next state of the whole block
  always_comb begin
    next_st        = st;
    ev             = '0;
    next_st.enc_we = 1'b0;
    next_st.ack    = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.rdata  = 32'h0;

    // Register writes with byte lanes
    if (wr) begin
      case (wb_adr_i)
        CMW_CTRL: begin
          if (wb_sel_i[0]) begin
            next_st.regs.mode = wb_dat_i[2:0];
          end
        end
        CMW_LIMIT: begin
          next_st.regs.limit = (st.regs.limit & ~wmask[15:0]) |
                               (wb_dat_i[15:0] & wmask[15:0]);
        end
        CMW_OFFSET: begin
          next_st.regs.offset = (st.regs.offset & ~wmask) |
                                (wb_dat_i & wmask);
        end
        CMW_ENABLE: begin
          if (wb_sel_i[0]) begin
            next_st.regs.enable = wb_dat_i[CMW_NEV-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Reads; unmapped addresses answer zero
    if (rd) begin
      case (wb_adr_i)
        CMW_CTRL:   next_st.rdata = {29'h0, st.regs.mode};
        CMW_LIMIT:  next_st.rdata = {16'h0, st.regs.limit};
        CMW_OFFSET: next_st.rdata = st.regs.offset;
        CMW_POS:    next_st.rdata = st.reported_actual_position;
        CMW_STATUS: next_st.rdata = {28'h0, st.regs.status};
        CMW_ENABLE: next_st.rdata = {28'h0, st.regs.enable};
        CMW_STATE:  next_st.rdata = {st.mturn, 11'h0, st.enc_valid,
                                     st.mism, st.fsm};
        default:    next_st.rdata = 32'h0;
      endcase
    end

    // Losing the battery forgets the stored limit
    if (!battery_ok_i) begin
      next_st.enc_valid = 1'b0;                                  // [RULE8]
    end

    // Start-up sequence
    case (st.fsm)
      CMW_IDLE: begin
        if (start) begin
          next_st.fsm  = CMW_CHECK;
          next_st.mism = 1'b0;
        end
      end
      CMW_CHECK: begin
        if (cont && (!st.enc_valid || st.enc_limit != lim_eff)) begin
          // Expected on first use; needs another power-up
          next_st.enc_limit = lim_eff;                           // [RULE4]
          next_st.enc_valid = battery_ok_i;                      // [RULE8]
          next_st.enc_we    = 1'b1;                              // [RULE4]
          next_st.mism      = 1'b1;                              // [RULE1]
          ev[CMW_EV_MISM]   = 1'b1;                              // [RULE1]
          next_st.fsm       = CMW_IDLE;
        end else begin
          next_st.fsm = CMW_RUN;                                 // [RULE2]
        end
      end
      CMW_RUN: begin
        if (start) begin
          next_st.fsm = CMW_CHECK;
        end
        // Simultaneous steps cancel out
        if (enc_step_up_i && !enc_step_dn_i) begin
          if (st.mturn >= lim_eff) begin
            next_st.mturn = 16'h0000;                            // [RULE9]
            ev[CMW_EV_WRAP] = cont;
            ev[CMW_EV_OVF]  = !cont;                             // [RULE10]
          end else begin
            next_st.mturn = st.mturn + 16'h0001;
          end
        end else if (enc_step_dn_i && !enc_step_up_i) begin
          if (st.mturn == 16'h0000) begin
            next_st.mturn = lim_eff;                             // [RULE9]
            ev[CMW_EV_WRAP] = cont;
            ev[CMW_EV_OVF]  = !cont;                             // [RULE10]
          end else begin
            next_st.mturn = st.mturn - 16'h0001;
          end
        end
        next_st.reported_actual_position = pos[31:0];                                // [RULE11]
      end
      default: begin
        next_st.fsm = CMW_IDLE;
      end
    endcase

    // Parameter check runs all the time
    next_st.perr    = bad_ofs;                                   // [RULE3]
    ev[CMW_EV_PERR] = bad_ofs;

    // Sticky status: a new event beats a clear in the same cycle
    next_st.regs.status = (st.regs.status & ~clr) | ev;
    next_st.irq = |(next_st.regs.status & next_st.regs.enable);
  end

  // State register; the encoder copy survives soft start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.fsm <= CMW_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o       = st.rdata;
  assign wb_ack_o       = st.ack;
  assign enc_limit_o    = st.enc_limit;
  assign enc_limit_we_o = st.enc_we;
  assign reported_actual_position_o         = st.reported_actual_position;
  assign mismatch_o     = st.mism;
  assign param_err_o    = st.perr;
  assign irq_o          = st.irq;

  // Checks on the block's own outputs and internal state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  mism_raise_a: assert property ( // [RULE1]
    (st.fsm == CMW_CHECK) && cont && (st.enc_limit != lim_eff)
    |=> mismatch_o && enc_limit_we_o && (st.fsm == CMW_IDLE))
    else $error("mismatch not raised on changed limit");

  mism_quiet_a: assert property ( // [RULE2]
    (st.fsm == CMW_CHECK) && st.enc_valid && (st.enc_limit == lim_eff)
    |=> !mismatch_o && (st.fsm == CMW_RUN) && !enc_limit_we_o)
    else $error("mismatch raised with matching limit");

  offset_range_a: assert property ( // [RULE3]
    cont && ({8'h00, st.regs.offset} > span - 40'h1)
    |=> param_err_o ##0 st.regs.status[CMW_EV_PERR])
    else $error("offset out of range not flagged");

  enc_write_a: assert property ( // [RULE4]
    $rose(enc_limit_we_o) |-> $past(st.fsm == CMW_CHECK) &&
    (enc_limit_o == $past(lim_eff)))
    else $error("encoder limit write outside start-up");

  reported_actual_position_wrap_a: assert property ( // [RULE7]
    cont && (st.fsm == CMW_RUN) && $stable(span)
    |=> ({8'h00, reported_actual_position_o} < $past(span)))
    else $error("actual position beyond wrap point");

  battery_keep_a: assert property ( // [RULE8]
    battery_ok_i && (st.fsm != CMW_CHECK)
    |=> $stable(enc_limit_o))
    else $error("encoder limit changed without start-up");

  turn_up_a: assert property ( // [RULE9]
    (st.fsm == CMW_RUN) && enc_step_up_i && !enc_step_dn_i &&
    (st.mturn >= lim_eff) |=> (st.mturn == 16'h0000))
    else $error("multi-turn did not wrap to zero");

  turn_down_a: assert property ( // [RULE9]
    (st.fsm == CMW_RUN) && enc_step_dn_i && !enc_step_up_i &&
    (st.mturn == 16'h0000) |=> (st.mturn == $past(lim_eff)))
    else $error("multi-turn did not wrap to limit");

  no_overflow_a: assert property ( // [RULE10]
    cont && $stable(st.regs.mode) && !st.regs.status[CMW_EV_OVF]
    |=> !st.regs.status[CMW_EV_OVF])
    else $error("overflow reported in continuous mode");

  pos_build_a: assert property ( // [RULE11]
    (st.fsm == CMW_RUN) && !cont ##1 (st.fsm == CMW_RUN)
    |-> reported_actual_position_o == 32'($past(raw) + {8'h00, $past(st.regs.offset)}))
    else $error("actual position formula broken");

endmodule // cmw_wrap

//--- test/cmw_host_model.sv
// Host controller model: command position seeded and wrapped
`timescale 1ns/1ns
module cmw_host_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        seed_i,
  input  wire logic [31:0] seed_val_i,
  input  wire logic [15:0] lim_i,
  input  wire logic        step_up_i,
  input  wire logic        step_dn_i,
  output logic      [31:0] cmd_o
);
  logic [63:0] span;
  // One full wrap; a limit of 0 is not modelled
  assign span = ({48'h0, lim_i} + 64'h1) << 23;
  // Seed from read position, then move one turn per step
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_o <= 32'h0;
    end else if (seed_i) begin
      cmd_o <= seed_val_i;
    end else if (step_up_i && !step_dn_i) begin
      cmd_o <= 32'((64'(cmd_o) + 64'h800000) % span);
    end else if (step_dn_i && !step_up_i) begin
      cmd_o <= 32'((64'(cmd_o) + span - 64'h800000) % span);
    end
  end
endmodule // cmw_host_model

//--- test/tb.sv
// Self-checking bench of the multi-turn wrap block
`timescale 1ns/1ns
module tb;
  import cmw_pkg::*;
  localparam logic [15:0] LIM = 16'h2;
  localparam logic [31:0] OFS = 32'h2710;
  logic        clk_i, rstn_i, cyc, stb, we, pu, bat, up, dn, sp;
  logic        ack, elim_we, mism, perr, irq;
  logic [7:0]  adr;
  logic [15:0] elim;
  logic [22:0] sgl;
  logic [31:0] dat, rd, rdo, reported_actual_position, cmd, sv;
  int          n_fail, check_count, seed, m, wcnt;
  // Clock of 40 ns
  always #20 clk_i = ~clk_i;
  cmw_wrap u_cmw_wrap (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .power_up_i(pu),
    .battery_ok_i(bat), .enc_single_i(sgl), .enc_step_up_i(up),
    .enc_step_dn_i(dn), .enc_limit_o(elim), .enc_limit_we_o(elim_we),
    .reported_actual_position_o(reported_actual_position), .mismatch_o(mism), .param_err_o(perr), .irq_o(irq));
  cmw_host_model u_cmw_host_model (.clk_i(clk_i), .rstn_i(rstn_i),
    .seed_i(sp), .seed_val_i(sv), .lim_i(LIM), .step_up_i(up),
    .step_dn_i(dn), .cmd_o(cmd));
  // Encoder-side limit write pulses
  always @(posedge clk_i) if (elim_we === 1'b1) wcnt++;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle; ack and read data taken at one rising edge
  // No local limit: only the watchdog may end a stuck wait
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdo;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic pwr();
    @(posedge clk_i) pu <= 1'b1;
    @(posedge clk_i) pu <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Multi-turn count model wraps at the limit
  task automatic step(input logic u);
    @(posedge clk_i) {up, dn} <= {u, !u};
    @(posedge clk_i) {up, dn} <= 2'b00;
    if (u) m = (m == LIM) ? 0 : m + 1;
    else m = (m == 0) ? int'(LIM) : m - 1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic [31:0] exp_pos(int mt, logic [22:0] s);
    logic [63:0] span;
    span = ({48'h0, LIM} + 64'h1) << 23;
    return 32'(((64'(mt) << 23) + 64'(s) + 64'(OFS)) % span);
  endfunction
  task automatic wrap_up();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {clk_i, rstn_i, cyc, stb, we, pu, up, dn, sp} = 9'h0;
    {adr, dat, sv, m, wcnt, n_fail, check_count} = '0;
    bat = 1'b1;
    seed = 32'h569d;
    sgl = 23'($random(seed));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'({mism, perr, irq, elim_we}), 32'h0);
    wb(1'b1, CMW_CTRL, 32'h4);
    wb(1'b1, CMW_LIMIT, 32'(LIM));
    wb(1'b1, CMW_OFFSET, OFS);
    wb(1'b1, CMW_ENABLE, 32'h1);
    pwr();
    chk(32'(mism), 32'h1);
    chk(32'(wcnt), 32'h1);
    chk(32'(elim), 32'(LIM));
    chk(32'(irq), 32'h1);
    wb(1'b0, CMW_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wb(1'b1, CMW_CLEAR, 32'h1);
    @(negedge clk_i);
    chk(32'(irq), 32'h0);
    $display("test first start done");
    pwr();
    chk(32'(mism), 32'h0);
    wb(1'b0, CMW_POS, 32'h0);
    chk(rd, exp_pos(0, sgl));
    // Host seeds its command from the read position
    @(posedge clk_i) {sp, sv} <= {1'b1, rd};
    @(posedge clk_i) sp <= 1'b0;
    step(1'b0);
    for (int i = 0; i < 40; i++) begin
      chk(reported_actual_position, exp_pos(m, sgl));
      chk(reported_actual_position, cmd);
      step(1'($random(seed)));
    end
    wb(1'b0, CMW_STATUS, 32'h0);
    chk(rd & 32'hc, 32'h8);
    $display("test wrap done");
    wb(1'b1, CMW_OFFSET, 32'({16'h0, LIM} + 32'h1) << 23);
    repeat (2) @(negedge clk_i);
    chk(32'(perr), 32'h1);
    wb(1'b1, CMW_OFFSET, (32'({16'h0, LIM} + 32'h1) << 23) - 32'h1);
    repeat (2) @(negedge clk_i);
    chk(32'(perr), 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("test offset done");
    @(posedge clk_i) bat <= 1'b0;
    @(posedge clk_i) bat <= 1'b1;
    pwr();
    chk(32'(mism), 32'h1);
    chk(32'(wcnt), 32'h2);
    $display("test battery done");
    // Other modes: no range check, no mismatch, no wrap at the limit
    wb(1'b1, CMW_OFFSET, (32'(LIM) + 32'h1) << 23);
    wb(1'b1, CMW_CTRL, 32'h0);
    pwr();
    chk(32'({mism, perr}), 32'h0);
    chk(reported_actual_position, 32'((m + int'(LIM) + 1) << 23) + 32'(sgl));
    step(m == 0);
    chk(reported_actual_position, 32'((m + int'(LIM) + 1) << 23) + 32'(sgl));
    $display("test other mode done");
    wrap_up();
  end
endmodule // tb
